//--- smpt_counter.sv
// 16-bit time base with period, rising and falling compare
// assumes reset events are one-cycle pulses on core_clk
`timescale 1ns/100ps
`default_nettype none
module smpt_counter (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	smpt_tick_if.snk         tick_if,
	input  wire logic        per_sync_en,
	input  wire logic        ext_reset,
	input  wire logic [15:0] period_cnt,
	input  wire logic [15:0] rise_cnt,
	input  wire logic [15:0] fall_cnt,
	output logic      [15:0] count,
	output logic             carry,
	output logic             sync_period,
	output logic             period_evt,
	output logic             rise_evt,
	output logic             fall_evt
);
	logic [15:0] count_reg;
	logic [15:0] count_next;

	// compares only count on controller clock ticks
	assign sync_period = tick_if.tick && per_sync_en && (count_reg == period_cnt);
	assign rise_evt    = tick_if.tick && (count_reg == rise_cnt);
	assign fall_evt    = tick_if.tick && (count_reg == fall_cnt);
	assign period_evt  = tick_if.run && (sync_period || ext_reset);
	assign carry       = tick_if.tick && !period_evt && (count_reg == smpt_pkg::COUNT_MAX);

	// any period event clears the count, else one step per tick with wrap
	assign count_next = period_evt ? smpt_pkg::COUNT_RESET :
		(tick_if.tick ? count_reg + 16'h0001 : count_reg);
	assign count = count_reg;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			count_reg <= smpt_pkg::COUNT_RESET;
		end else begin
			count_reg <= tick_if.run ? count_next : smpt_pkg::COUNT_RESET;
		end
	end

	a_count_step: assert property (@(posedge core_clk) disable iff (!resetn)
		tick_if.tick && !period_evt |=> count_reg == $past(count_reg) + 16'h0001)
		else $error("count did not step on tick");
	a_period_clear: assert property (@(posedge core_clk) disable iff (!resetn)
		period_evt |=> count_reg == 16'h0000)
		else $error("period event did not clear count");
	a_count_hold: assert property (@(posedge core_clk) disable iff (!resetn)
		tick_if.run && !tick_if.tick && !period_evt |=> $stable(count_reg))
		else $error("count moved without tick");
endmodule
`default_nettype wire

//--- smpt_peer_model.sv
// peer pwm instances that drive the sync inputs of the timer under test
// assumes core_clk; each armed peer pulses its sync output every gap+1 cycles
`timescale 1ns/100ps
`default_nettype none
module smpt_peer_model (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [3:0] arm,
	input  wire logic [7:0] gap,
	output logic      [3:0] peer_sync
);
	logic [7:0] cnt_reg;

	// ------------------------------------------------------------
	// master period of the peers
	// ------------------------------------------------------------
	// an armed peer is a master whose period ends every gap+1 cycles
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg   <= 8'h00;
			peer_sync <= 4'h0;
		end else begin
			cnt_reg   <= (cnt_reg >= gap) ? 8'h00 : cnt_reg + 8'h01;
			peer_sync <= (cnt_reg >= gap) ? arm : 4'h0;
		end
	end
endmodule
`default_nettype wire

//--- smpt_pkg.sv
// package of constants for the pwm time base block
// assumes one core clock; all offsets are byte addresses on a 32-bit avalon-mm slave
package smpt_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [4:0] OFF_CTRL      = 5'h00;
	localparam logic [4:0] OFF_PERIOD    = 5'h04;
	localparam logic [4:0] OFF_RISE      = 5'h08;
	localparam logic [4:0] OFF_FALL      = 5'h0C;
	localparam logic [4:0] OFF_COUNT     = 5'h10;
	localparam logic [4:0] OFF_INT_FLAG  = 5'h14;
	localparam logic [4:0] OFF_INT_EN    = 5'h18;
	localparam logic [4:0] OFF_FAST_FREQ = 5'h1C;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT   = 0;
	localparam int CTRL_CLK_SEL_LSB  = 1;
	localparam int CTRL_PSC_LSB      = 3;
	localparam int CTRL_PER_SYNC_BIT = 5;
	localparam int CTRL_CARRY_INT    = 6;
	localparam int CTRL_PER_INT      = 7;
	localparam int CTRL_SYNC_SEL_LSB = 8;
	localparam int CTRL_SYNC_EN_BIT  = 12;
	localparam logic [12:0] CTRL_RESET = 13'h0000;

	// ------------------------------------------------------------
	// interrupt flag and enable fields (same layout)
	// ------------------------------------------------------------
	localparam int INT_TIMED_BIT    = 0;
	localparam int INT_SHUTDOWN_BIT = 1;
	localparam logic [1:0] INT_RESET = 2'h0;

	// ------------------------------------------------------------
	// compare registers and counter
	// ------------------------------------------------------------
	localparam logic [15:0] CMP_RESET   = 16'h0000;
	localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	// ------------------------------------------------------------
	// clock sources
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SMPT_SRC_SYS_OSC  = 2'b00,
		SMPT_SRC_FAST     = 2'b01,
		SMPT_SRC_CLK_PIN  = 2'b10,
		SMPT_SRC_RESERVED = 2'b11
	} smpt_src_type;
	localparam int HF_OSC_MHZ    = 16;
	localparam int FAST_MULT     = 4;
	localparam int FAST_CLK_MHZ  = HF_OSC_MHZ * FAST_MULT;
	localparam int PSC_CNT_WIDTH = 3;
endpackage

//--- smpt_prescaler.sv
// divider that turns selected source ticks into controller clock ticks
// assumes src_tick is a one-cycle pulse on core_clk
`timescale 1ns/100ps
`default_nettype none
module smpt_prescaler (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        enable,
	input  wire logic        src_tick,
	input  wire logic [1:0]  div_sel,
	smpt_tick_if.src         tick_if
);
	logic [smpt_pkg::PSC_CNT_WIDTH-1:0] cnt_reg;
	logic [smpt_pkg::PSC_CNT_WIDTH-1:0] cnt_next;
	logic [smpt_pkg::PSC_CNT_WIDTH-1:0] mask;

	// divide by 1, 2, 4 or 8
	assign mask     = smpt_pkg::PSC_CNT_WIDTH'((4'h1 << div_sel) - 4'h1);
	assign cnt_next = src_tick ? cnt_reg + 3'h1 : cnt_reg;
	assign tick_if.tick = enable && src_tick && ((cnt_reg & mask) == mask);
	assign tick_if.run  = enable;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= 3'h0;
		end else begin
			cnt_reg <= enable ? cnt_next : 3'h0;
		end
	end
endmodule
`default_nettype wire

//--- smpt_tick_if.sv
// carrier for the prescaled controller clock tick between the prescaler and the counter
// assumes both ends sit on core_clk
`timescale 1ns/100ps
`default_nettype none
interface smpt_tick_if;
	logic tick;
	logic run;
	modport src (output tick, output run);
	modport snk (input tick, input run);
endinterface
`default_nettype wire

//--- smpt_timebase.sv
// top of the pwm time base: clock select, prescale, counter, registers, interrupts
// assumes an avalon-mm master on core_clk, oscillator sources as one-cycle ticks and a synchronous clock pin level
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module smpt_timebase #(
	parameter int N_INST = 4
) (
	input  wire logic                      core_clk,
	input  wire logic                      resetn,
	// avalon-mm slave
	input  wire logic [4:0]                address,
	input  wire logic                      read,
	input  wire logic                      write,
	input  wire logic [31:0]               writedata,
	output logic      [31:0]               readdata,
	output logic                           waitrequest,
	// clock sources: oscillators as ticks, the pin as a synchronous level
	input  wire logic                      sys_osc_tick,
	input  wire logic                      fast_clk_tick,
	input  wire logic                      controller_clock_pin,
	// timer links
	input  wire logic [N_INST-1:0]         peer_sync_in,
	input  wire logic                      async_period_in,
	input  wire logic                      shutdown_evt,
	output logic                           sync_out,
	output logic      [15:0]               timer_count,
	output logic                           timer_carry,
	output logic                           rise_evt,
	output logic                           fall_evt,
	output logic                           ctrl_clk_tick,
	output logic                           irq
);
	localparam int SEL_W = (N_INST > 1) ? $clog2(N_INST) : 1;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [12:0] ctrl_reg;
	logic [15:0] period_reg;
	logic [15:0] rise_reg;
	logic [15:0] fall_reg;
	logic [1:0]  int_flag_reg;
	logic [1:0]  int_flag_next;
	logic [1:0]  int_enable_reg;
	logic        ack_reg;
	logic [31:0] readdata_reg;
	logic        pin_prev_reg;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire        req       = read || write;
	wire        bus_fire  = req && ack_reg;
	wire        wr_fire   = write && ack_reg;
	wire        sel_ctrl  = (address == smpt_pkg::OFF_CTRL);
	wire        sel_per   = (address == smpt_pkg::OFF_PERIOD);
	wire        sel_rise  = (address == smpt_pkg::OFF_RISE);
	wire        sel_fall  = (address == smpt_pkg::OFF_FALL);
	wire        sel_cnt   = (address == smpt_pkg::OFF_COUNT);
	wire        sel_flag  = (address == smpt_pkg::OFF_INT_FLAG);
	wire        sel_en    = (address == smpt_pkg::OFF_INT_EN);
	wire        sel_freq  = (address == smpt_pkg::OFF_FAST_FREQ);
	wire [1:0]  flag_clr  = (wr_fire && sel_flag) ? writedata[1:0] : 2'h0;

	// one wait cycle per access; read data are loaded before the release
	assign waitrequest = req && !ack_reg;
	assign readdata    = readdata_reg;

	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	wire                   mod_enable  = ctrl_reg[smpt_pkg::CTRL_ENABLE_BIT];
	wire [1:0]             clk_sel     = ctrl_reg[smpt_pkg::CTRL_CLK_SEL_LSB +: 2];
	wire [1:0]             psc_sel     = ctrl_reg[smpt_pkg::CTRL_PSC_LSB +: 2];
	wire                   per_sync_en = ctrl_reg[smpt_pkg::CTRL_PER_SYNC_BIT];
	wire                   carry_int   = ctrl_reg[smpt_pkg::CTRL_CARRY_INT];
	wire                   per_int     = ctrl_reg[smpt_pkg::CTRL_PER_INT];
	wire [3:0]             sync_sel    = ctrl_reg[smpt_pkg::CTRL_SYNC_SEL_LSB +: 4];
	wire                   sync_src_en = ctrl_reg[smpt_pkg::CTRL_SYNC_EN_BIT];

	// ------------------------------------------------------------
	// clock source select
	// ------------------------------------------------------------
	// the pin is taken as synchronous; its rising edge is one source tick
	wire pin_tick = controller_clock_pin && !pin_prev_reg;
	smpt_pkg::smpt_src_type src_kind;
	logic src_tick;
	assign src_kind = smpt_pkg::smpt_src_type'(clk_sel);

	always_comb begin
		unique case (src_kind)
			smpt_pkg::SMPT_SRC_SYS_OSC:  src_tick = sys_osc_tick;
			smpt_pkg::SMPT_SRC_FAST:     src_tick = fast_clk_tick;
			smpt_pkg::SMPT_SRC_CLK_PIN:  src_tick = pin_tick;
			smpt_pkg::SMPT_SRC_RESERVED: src_tick = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// peer sync select
	// ------------------------------------------------------------
	// a selection beyond the instance count picks nothing
	wire sel_in_range = (32'(sync_sel) < N_INST);
	wire peer_sync    = sync_src_en && sel_in_range && peer_sync_in[SEL_W'(sync_sel)];
	wire ext_reset    = peer_sync || async_period_in;

	// ------------------------------------------------------------
	// prescaler and counter
	// ------------------------------------------------------------
	smpt_tick_if tick_bus ();
	logic sync_period;
	logic period_evt;

	smpt_prescaler u_psc (
		.core_clk (core_clk),
		.resetn   (resetn),
		.enable   (mod_enable),
		.src_tick (src_tick),
		.div_sel  (psc_sel),
		.tick_if  (tick_bus.src)
	);

	smpt_counter u_cnt (
		.core_clk    (core_clk),
		.resetn      (resetn),
		.tick_if     (tick_bus.snk),
		.per_sync_en (per_sync_en),
		.ext_reset   (ext_reset),
		.period_cnt  (period_reg),
		.rise_cnt    (rise_reg),
		.fall_cnt    (fall_reg),
		.count       (timer_count),
		.carry       (timer_carry),
		.sync_period (sync_period),
		.period_evt  (period_evt),
		.rise_evt    (rise_evt),
		.fall_evt    (fall_evt)
	);

	assign sync_out      = period_evt;
	assign ctrl_clk_tick = tick_bus.tick;

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	// set wins over a write-one clear in the same cycle
	wire timed_set = (carry_int && timer_carry) || (per_int && sync_period);
	wire sd_set    = mod_enable && shutdown_evt;
	wire [1:0] flag_set = {sd_set, timed_set};
	assign int_flag_next = (int_flag_reg & ~flag_clr) | flag_set;
	assign irq = (int_flag_reg[smpt_pkg::INT_TIMED_BIT]
			&& int_enable_reg[smpt_pkg::INT_TIMED_BIT])
		|| (int_flag_reg[smpt_pkg::INT_SHUTDOWN_BIT]
			&& int_enable_reg[smpt_pkg::INT_SHUTDOWN_BIT]);

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	logic [31:0] rd_mux;
	assign rd_mux =
		sel_ctrl ? {19'h0, ctrl_reg} :
		sel_per  ? {16'h0, period_reg} :
		sel_rise ? {16'h0, rise_reg} :
		sel_fall ? {16'h0, fall_reg} :
		sel_cnt  ? {16'h0, timer_count} :
		sel_flag ? {30'h0, int_flag_reg} :
		sel_en   ? {30'h0, int_enable_reg} :
		sel_freq ? 32'(smpt_pkg::FAST_CLK_MHZ) :
		32'h0000_0000;

	// ------------------------------------------------------------
	// register process
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ack_reg      <= 1'b0;
			readdata_reg <= 32'h0000_0000;
			pin_prev_reg <= 1'b0;
		end else begin
			ack_reg      <= req && !ack_reg;
			pin_prev_reg <= controller_clock_pin;
			if (read && !ack_reg) begin
				readdata_reg <= rd_mux;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg       <= smpt_pkg::CTRL_RESET;
			period_reg     <= smpt_pkg::CMP_RESET;
			rise_reg       <= smpt_pkg::CMP_RESET;
			fall_reg       <= smpt_pkg::CMP_RESET;
			int_enable_reg <= smpt_pkg::INT_RESET;
		end else if (wr_fire) begin
			if (sel_ctrl) begin
				ctrl_reg <= writedata[12:0];
			end
			if (sel_per) begin
				period_reg <= writedata[15:0];
			end
			if (sel_rise) begin
				rise_reg <= writedata[15:0];
			end
			if (sel_fall) begin
				fall_reg <= writedata[15:0];
			end
			if (sel_en) begin
				int_enable_reg <= writedata[1:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			int_flag_reg <= smpt_pkg::INT_RESET;
		end else begin
			int_flag_reg <= int_flag_next;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_bus_req;
		req && !ack_reg;
	endsequence

	sequence s_bus_ack;
		bus_fire && !waitrequest;
	endsequence

	a_bus_answer: assert property (@(posedge core_clk) disable iff (!resetn)
		s_bus_req ##1 req |-> s_bus_ack)
		else $error("bus access not answered after one wait cycle");

	a_clk_select: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_sel == 2'h1 && !fast_clk_tick |-> !src_tick)
		else $error("fast source selected but other source ticked");

	a_div_eight: assert property (@(posedge core_clk) disable iff (!resetn)
		tick_bus.tick && psc_sel == 2'h3 && mod_enable
		|=> u_psc.cnt_reg == 3'h0)
		else $error("divide by eight did not restart its count");

	a_carry_flag: assert property (@(posedge core_clk) disable iff (!resetn)
		timer_carry && carry_int |=> int_flag_reg[smpt_pkg::INT_TIMED_BIT])
		else $error("carry did not set timed flag");

	a_timed_gate: assert property (@(posedge core_clk) disable iff (!resetn)
		!int_enable_reg[smpt_pkg::INT_TIMED_BIT] && !int_flag_reg[smpt_pkg::INT_SHUTDOWN_BIT]
		|-> !irq)
		else $error("timed interrupt passed a closed enable");

	a_sd_irq: assert property (@(posedge core_clk) disable iff (!resetn)
		sd_set && int_enable_reg[smpt_pkg::INT_SHUTDOWN_BIT] && !wr_fire |=> irq)
		else $error("shutdown event did not raise interrupt");

	a_disabled_idle: assert property (@(posedge core_clk) disable iff (!resetn)
		!mod_enable ##1 !mod_enable |-> timer_count == 16'h0000 && !ctrl_clk_tick)
		else $error("disabled instance still running");

	a_peer_reset: assert property (@(posedge core_clk) disable iff (!resetn)
		mod_enable && peer_sync |-> sync_out ##1 timer_count == 16'h0000)
		else $error("peer sync did not reset timer");

	a_wrap_carry: assert property (@(posedge core_clk) disable iff (!resetn)
		timer_carry |=> timer_count == 16'h0000)
		else $error("carry without wrap to zero");

	a_fast_freq: assert property (@(posedge core_clk) disable iff (!resetn)
		read && sel_freq && !ack_reg |=> readdata == 32'h0000_0040)
		else $error("fast clock frequency misreported");

	// ------------------------------------------------------------
	// event and interrupt checks
	// ------------------------------------------------------------
	sequence s_ext_hit;
		mod_enable && ext_reset;
	endsequence

	sequence s_count_zero;
		timer_count == 16'h0000;
	endsequence

	a_ext_period: assert property (@(posedge core_clk) disable iff (!resetn)
		s_ext_hit |-> sync_out ##1 s_count_zero)
		else $error("external period event did not clear timer");

	a_sync_match: assert property (@(posedge core_clk) disable iff (!resetn)
		ctrl_clk_tick && per_sync_en && timer_count == period_reg |-> sync_out)
		else $error("period match gave no period event");

	a_carry_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
		timer_carry |=> !timer_carry)
		else $error("carry longer than one cycle");

	a_reserved_src: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_sel == 2'h3 |-> !ctrl_clk_tick)
		else $error("reserved source produced a tick");

	a_pin_select: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_sel == 2'h2 && !controller_clock_pin |-> !src_tick)
		else $error("pin source ticked with pin low");

	a_sys_select: assert property (@(posedge core_clk) disable iff (!resetn)
		clk_sel == 2'h0 && !sys_osc_tick |-> !src_tick)
		else $error("system source ticked without oscillator");

	a_sel_range: assert property (@(posedge core_clk) disable iff (!resetn)
		!sel_in_range |-> !peer_sync)
		else $error("out of range sync index selected a peer");

	a_flag_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
		int_flag_reg[0] && !flag_clr[0] |=> int_flag_reg[0])
		else $error("timed flag dropped without clear");

	a_flag_clear: assert property (@(posedge core_clk) disable iff (!resetn)
		flag_clr[0] && !timed_set |=> !int_flag_reg[0])
		else $error("timed flag not cleared by write one");

	a_set_wins: assert property (@(posedge core_clk) disable iff (!resetn)
		timed_set |=> int_flag_reg[0])
		else $error("timed event did not set flag");

	a_sd_gate: assert property (@(posedge core_clk) disable iff (!resetn)
		!int_enable_reg[1] && !int_flag_reg[0] |-> !irq)
		else $error("shutdown interrupt passed a closed enable");

	a_div_one: assert property (@(posedge core_clk) disable iff (!resetn)
		psc_sel == 2'h0 && mod_enable && src_tick |-> tick_bus.tick)
		else $error("divide by one dropped a source tick");

	a_tick_source: assert property (@(posedge core_clk) disable iff (!resetn)
		tick_bus.tick |-> src_tick && mod_enable)
		else $error("controller tick without enabled source tick");
endmodule
`default_nettype wire

//--- smpt_timebase_tb_top.sv
// self-checking bench for the pwm time base
// assumes the block is an avalon-mm slave with one wait cycle; oscillator sources are driven as ticks, the pin as a toggling level
`timescale 1ns/100ps
`default_nettype none
module smpt_timebase_tb_top;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [4:0]  address = 5'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        sys_osc_tick = 1'b0;
	logic        fast_clk_tick = 1'b0;
	logic        controller_clock_pin = 1'b0;
	logic [3:0]  peer_sync_in;
	logic        async_period_in = 1'b0;
	logic        shutdown_evt = 1'b0;
	logic        sync_out;
	logic [15:0] timer_count;
	logic        timer_carry;
	logic        rise_evt;
	logic        fall_evt;
	logic        ctrl_clk_tick;
	logic        irq;
	logic        sys_on = 1'b0;
	logic        fast_on = 1'b0;
	logic        pin_on = 1'b0;
	logic [3:0]  arm = 4'h0;
	logic [7:0]  gap = 8'h09;
	int          n_mismatch = 0;
	int          compares = 0;

	smpt_timebase smpt_timebase_i (.core_clk(core_clk), .resetn(resetn), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .sys_osc_tick(sys_osc_tick), .fast_clk_tick(fast_clk_tick),
		.controller_clock_pin(controller_clock_pin), .peer_sync_in(peer_sync_in),
		.async_period_in(async_period_in), .shutdown_evt(shutdown_evt), .sync_out(sync_out),
		.timer_count(timer_count), .timer_carry(timer_carry), .rise_evt(rise_evt),
		.fall_evt(fall_evt), .ctrl_clk_tick(ctrl_clk_tick), .irq(irq));
	smpt_peer_model smpt_peer_model_i (.core_clk(core_clk), .resetn(resetn), .arm(arm),
		.gap(gap), .peer_sync(peer_sync_in));

	always #50 core_clk = ~core_clk;

	// ------------------------------------------------------------
	// clock sources; the pin toggles, so it gives one rising edge per two cycles
	// ------------------------------------------------------------
	always @(posedge core_clk) begin
		sys_osc_tick <= sys_on;
		fast_clk_tick <= fast_on;
		controller_clock_pin <= pin_on & ~controller_clock_pin;
	end

	// ------------------------------------------------------------
	// compare, bus and closing tasks
	// ------------------------------------------------------------
	task chk_w(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t word %h expected %h", $time, g, e);
		end
	endtask
	task chk_b(input logic g, input logic e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t flag %b expected %b", $time, g, e);
		end
	endtask
	// request held until waitrequest is seen low at a rising edge
	task xfer(input logic w, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] d);
		int k;
		@(posedge core_clk);
		address <= a;
		writedata <= wd;
		write <= w;
		read <= ~w;
		for (k = 0; k < 20; k++) begin
			@(posedge core_clk);
			if (waitrequest === 1'b0)
				break;
		end
		if (k == 20)
			chk_b(waitrequest, 1'b0);
		d = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task wr(input logic [4:0] a, input logic [31:0] v);
		logic [31:0] d;
		xfer(1'b1, a, v, d);
	endtask
	task rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] d;
		xfer(1'b0, a, 32'h0, d);
		chk_w(d, e);
	endtask
	task complete_run;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_regs;
		int i;
		for (i = 0; i < 7; i++)
			rd(5'(i * 4), 32'h0);
		rd(smpt_pkg::OFF_FAST_FREQ, 32'h40);
		wr(smpt_pkg::OFF_FAST_FREQ, 32'h0);
		rd(smpt_pkg::OFF_FAST_FREQ, 32'h40);
		wr(smpt_pkg::OFF_PERIOD, 32'hFFFFFFFF);
		rd(smpt_pkg::OFF_PERIOD, 32'h0000FFFF);
		wr(smpt_pkg::OFF_PERIOD, 32'h0);
		rd(5'h02, 32'h0);
		$display("done: registers");
	endtask
	// every source and divider; the window drains so late ticks still count
	task t_clk_sel;
		logic [15:0] n;
		logic [15:0] e;
		int s;
		int p;
		int i;
		for (s = 0; s < 5; s++) begin
			for (p = 0; p < 4; p++) begin
				wr(smpt_pkg::OFF_CTRL, 32'h0);
				wr(smpt_pkg::OFF_CTRL, 32'((s < 4) | (s % 4) << 1 | p << 3));
				n = 16'h0;
				sys_on <= (s == 0 || s == 4);
				fast_on <= (s == 1);
				pin_on <= (s == 2);
				for (i = 0; i < 70; i++) begin
					@(posedge core_clk);
					n = n + 16'(ctrl_clk_tick);
					if (i == 63) begin
						sys_on <= 1'b0;
						fast_on <= 1'b0;
						pin_on <= 1'b0;
					end
				end
				e = (s > 2) ? 16'h0000 : ((s == 2) ? 16'h0020 : 16'h0040) >> p;
				chk_w(32'(n), 32'(e));
				rd(smpt_pkg::OFF_COUNT, 32'(e));
			end
		end
		wr(smpt_pkg::OFF_CTRL, 32'h0);
		$display("done: clock select");
	endtask
	task t_sync_period;
		int i;
		wr(smpt_pkg::OFF_PERIOD, 32'h5);
		wr(smpt_pkg::OFF_RISE, 32'h2);
		wr(smpt_pkg::OFF_FALL, 32'h4);
		wr(smpt_pkg::OFF_INT_EN, 32'h1);
		wr(smpt_pkg::OFF_CTRL, 32'h1 | 32'h1 << 5 | 32'h1 << 7);
		sys_on <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			chk_b(rise_evt, ctrl_clk_tick & (timer_count == 16'h0002));
			chk_b(fall_evt, ctrl_clk_tick & (timer_count == 16'h0004));
			chk_b(sync_out, ctrl_clk_tick & (timer_count == 16'h0005));
			chk_b(timer_count <= 16'h0005, 1'b1);
		end
		rd(smpt_pkg::OFF_INT_FLAG, 32'h1);
		chk_b(irq, 1'b1);
		wr(smpt_pkg::OFF_CTRL, 32'h0);
		wr(smpt_pkg::OFF_INT_FLAG, 32'h1);
		rd(smpt_pkg::OFF_INT_FLAG, 32'h0);
		chk_b(irq, 1'b0);
		wr(smpt_pkg::OFF_PERIOD, 32'h0);
		$display("done: sync period");
	endtask
	task t_peer;
		int i;
		int hits;
		logic hit;
		hits = 0;
		hit = 1'b0;
		wr(smpt_pkg::OFF_CTRL, 32'h1 | 32'h1 << 12 | 32'h2 << 8);
		arm <= 4'b0010;
		repeat (40) @(posedge core_clk);
		chk_b(timer_count > 16'h0019, 1'b1);
		arm <= 4'b0100;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			if (hit)
				chk_w(32'(timer_count), 32'h0);
			hit = peer_sync_in[2];
			if (hit) begin
				hits++;
				chk_b(sync_out, 1'b1);
			end
		end
		chk_b(hits > 2, 1'b1);
		arm <= 4'h0;
		@(posedge core_clk);
		async_period_in <= 1'b1;
		@(posedge core_clk);
		async_period_in <= 1'b0;
		chk_b(sync_out, 1'b1);
		@(posedge core_clk);
		chk_w(32'(timer_count), 32'h0);
		sys_on <= 1'b0;
		wr(smpt_pkg::OFF_CTRL, 32'h0);
		$display("done: peer sync");
	endtask
	task t_shutdown;
		wr(smpt_pkg::OFF_CTRL, 32'h7);
		wr(smpt_pkg::OFF_INT_EN, 32'h2);
		@(posedge core_clk);
		shutdown_evt <= 1'b1;
		@(posedge core_clk);
		shutdown_evt <= 1'b0;
		rd(smpt_pkg::OFF_INT_FLAG, 32'h2);
		chk_b(irq, 1'b1);
		wr(smpt_pkg::OFF_INT_EN, 32'h1);
		rd(smpt_pkg::OFF_INT_EN, 32'h1);
		chk_b(irq, 1'b0);
		wr(smpt_pkg::OFF_INT_FLAG, 32'h2);
		rd(smpt_pkg::OFF_INT_FLAG, 32'h0);
		wr(smpt_pkg::OFF_CTRL, 32'h0);
		$display("done: shutdown interrupt");
	endtask
	// full 16-bit run: the only way to reach the wrap without a load
	task t_wrap;
		int k;
		wr(smpt_pkg::OFF_INT_EN, 32'h1);
		wr(smpt_pkg::OFF_CTRL, 32'h1 | 32'h1 << 6);
		sys_on <= 1'b1;
		for (k = 0; k < 70000; k++) begin
			@(posedge core_clk);
			if (timer_carry === 1'b1)
				break;
		end
		chk_w(32'(timer_count), 32'h0000FFFF);
		@(posedge core_clk);
		chk_w(32'(timer_count), 32'h0);
		rd(smpt_pkg::OFF_INT_FLAG, 32'h1);
		chk_b(irq, 1'b1);
		wr(smpt_pkg::OFF_INT_EN, 32'h0);
		rd(smpt_pkg::OFF_INT_EN, 32'h0);
		chk_b(irq, 1'b0);
		sys_on <= 1'b0;
		wr(smpt_pkg::OFF_CTRL, 32'h0);
		$display("done: wrap and carry");
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		t_regs;
		t_clk_sel;
		t_sync_period;
		t_peer;
		t_shutdown;
		t_wrap;
		complete_run;
	end
	initial begin
		#(100 * 90000);
		n_mismatch++;
		complete_run;
	end
endmodule
`default_nettype wire
